// *** hdl/hrw_pkg.sv ***
package hrw_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFS_BYP0_CTRL = 12'h0F0;
  localparam logic [ADDR_W-1:0] OFS_BYP0_MATCH = 12'h0F4;
  localparam logic [ADDR_W-1:0] OFS_BYP1_CTRL = 12'h0F8;
  localparam logic [ADDR_W-1:0] OFS_BYP1_MATCH = 12'h0FC;
  localparam logic [ADDR_W-1:0] OFS_TX_CMD_FREE = 12'h100;
  localparam logic [ADDR_W-1:0] OFS_TX_DATA_FREE = 12'h104;
  localparam logic [ADDR_W-1:0] OFS_PEER0_CTRL = 12'h158;
  localparam logic [ADDR_W-1:0] OFS_PEER0_MATCH = 12'h15C;
  localparam logic [ADDR_W-1:0] OFS_PEER1_CTRL = 12'h160;
  localparam logic [ADDR_W-1:0] OFS_PEER1_MATCH = 12'h164;
  localparam logic [ADDR_W-1:0] OFS_BYP2_CTRL = 12'h168;
  localparam logic [ADDR_W-1:0] OFS_BYP2_MATCH = 12'h16C;
  localparam logic [ADDR_W-1:0] OFS_BYP3_CTRL = 12'h170;
  localparam logic [ADDR_W-1:0] OFS_BYP3_MATCH = 12'h174;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int NUM_BYP = 4;
  localparam int NUM_PEER = 2;
  localparam int NUM_WIN = NUM_BYP + NUM_PEER;
  localparam int WIN_EN_BIT = 31;
  localparam int XLAT_EN_BIT = 30;
  localparam int TGT_HI = 29;
  localparam int TGT_UP_LO = 16;
  localparam int TGT_MID_HI = 15;
  localparam int BASE_HI = 31;
  localparam int BASE_LO = 16;
  localparam int MASK_HI = 15;
  localparam int MASK_LO = 0;
  localparam int WIN_ADDR_HI = 39;
  localparam int WIN_ADDR_LO = 24;
  localparam logic [31:0] WIN_RST = 32'h00000000;
  localparam logic [7:0] TX_FREE_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] match;
  } hrw_win_t;

  typedef enum logic [2:0] {
    FWD_INTERNAL = 3'b001,
    FWD_BYPASS = 3'b010,
    FWD_PEER = 3'b100
  } hrw_route_t;

  typedef enum logic [1:0] {
    WR_TAKE = 2'b01,
    WR_RESP = 2'b10
  } hrw_wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_RESP = 2'b10
  } hrw_rd_state_t;

  typedef struct packed {
    logic [7:0] cmd_b;
    logic [7:0] cmd_r;
    logic [7:0] nonposted_cmd_free_count;
    logic [7:0] posted_cmd_free_count;
    logic [7:0] data_r;
    logic [7:0] nonposted_data_free_count;
    logic [7:0] posted_data_free_count;
  } hrw_txfree_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [39:0] addr;
  } hrw_req_t;

  typedef struct packed {
    logic valid;
    logic write;
    hrw_route_t route;
    logic [53:0] addr;
  } hrw_fwd_t;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } hrw_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } hrw_axi_rsp_t;

endpackage : hrw_pkg

// *** hdl/hrw_top.sv ***
`timescale 1ns/100ps
module hrw_top
  import hrw_pkg::*;
(
  input wire logic clk, // Register clock, 40 MHz
  input wire logic arst_n, // Asynchronous reset
  input wire hrw_axi_req_t axi_req, // AXI4-Lite master side
  output hrw_axi_rsp_t axi_rsp, // AXI4-Lite slave answers
  input wire logic link_clk, // Link side clock
  input wire hrw_req_t rx_req, // Request received from the link
  input wire hrw_txfree_t tx_free, // Live free transmit buffer counts
  output hrw_fwd_t fwd // Routed request
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    hrw_axi_rsp_t rsp;
    hrw_wr_state_t wr_state;
    hrw_rd_state_t rd_state;
    logic aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    hrw_win_t [NUM_WIN-1:0] cfg;
    hrw_win_t [NUM_WIN-1:0] shadow;
    logic dirty;
    logic cfg_req;
    logic [1:0] ack_sync;
    logic [1:0] tx_sync;
    logic tx_ack;
    hrw_txfree_t tx;
  } hrw_cs_t;

  typedef struct packed {
    hrw_win_t [NUM_WIN-1:0] cfg;
    logic [1:0] req_sync;
    logic cfg_ack;
    hrw_txfree_t tx_hold;
    logic tx_req;
    logic [1:0] tx_ack_sync;
    hrw_fwd_t fwd;
  } hrw_ls_t;

  hrw_cs_t cs;
  hrw_cs_t next_cs;
  hrw_ls_t ls;
  hrw_ls_t next_ls;
  logic [1:0] link_rst_sync;
  logic link_rst_n;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic win_hit(input hrw_win_t w, input logic [39:0] a);
    logic [15:0] m;
    logic [15:0] b;
    m = w.match[MASK_HI:MASK_LO];
    b = w.match[BASE_HI:BASE_LO];
    return w.ctrl[WIN_EN_BIT] && ((a[WIN_ADDR_HI:WIN_ADDR_LO] & m) == (b & m));
  endfunction : win_hit

  function automatic logic [53:0] win_xlat(input hrw_win_t w, input logic [39:0] a);
    logic [15:0] m;
    logic [15:0] mid;
    m = w.match[MASK_HI:MASK_LO];
    mid = (a[WIN_ADDR_HI:WIN_ADDR_LO] & ~m) | (w.ctrl[TGT_MID_HI:0] & m);
    if (w.ctrl[XLAT_EN_BIT]) begin
      return {w.ctrl[TGT_HI:TGT_UP_LO], mid, a[WIN_ADDR_LO-1:0]};
    end
    return {14'h0000, a};
  endfunction : win_xlat

  function automatic logic [31:0] merge_strb(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_strb

  // Bit 4 marks a mapped address; slots 0..11 are window words, 12/13 counts
  function automatic logic [4:0] reg_decode(input logic [ADDR_W-1:0] a);
    if (a == OFS_BYP0_CTRL) begin
      return 5'h10;
    end else if (a == OFS_BYP0_MATCH) begin
      return 5'h11;
    end else if (a == OFS_BYP1_CTRL) begin
      return 5'h12;
    end else if (a == OFS_BYP1_MATCH) begin
      return 5'h13;
    end else if (a == OFS_BYP2_CTRL) begin
      return 5'h14;
    end else if (a == OFS_BYP2_MATCH) begin
      return 5'h15;
    end else if (a == OFS_BYP3_CTRL) begin
      return 5'h16;
    end else if (a == OFS_BYP3_MATCH) begin
      return 5'h17;
    end else if (a == OFS_PEER0_CTRL) begin
      return 5'h18;
    end else if (a == OFS_PEER0_MATCH) begin
      return 5'h19;
    end else if (a == OFS_PEER1_CTRL) begin
      return 5'h1A;
    end else if (a == OFS_PEER1_MATCH) begin
      return 5'h1B;
    end else if (a == OFS_TX_CMD_FREE) begin
      return 5'h1C;
    end else if (a == OFS_TX_DATA_FREE) begin
      return 5'h1D;
    end
    return 5'h00;
  endfunction : reg_decode

  // ----------------------------------------------------------------
  // Register domain
  // ----------------------------------------------------------------
  always_comb begin
    logic [4:0] wslot;
    logic [4:0] rslot;
    logic busy;
    wslot = reg_decode(cs.aw_addr);
    rslot = reg_decode(axi_req.araddr);
    busy = cs.cfg_req != cs.ack_sync[1];
    next_cs = cs;

    // Configuration handover toward the link domain
    next_cs.ack_sync = {cs.ack_sync[0], ls.cfg_ack};
    if (cs.dirty && !busy) begin
      next_cs.shadow = cs.cfg;
      next_cs.cfg_req = ~cs.cfg_req;
      next_cs.dirty = 1'b0;
    end

    // Free count snapshots from the link domain
    next_cs.tx_sync = {cs.tx_sync[0], ls.tx_req};
    if (cs.tx_sync[1] != cs.tx_ack) begin
      next_cs.tx = ls.tx_hold;
      next_cs.tx_ack = cs.tx_sync[1];
    end

    // Write channel
    if (axi_req.awvalid && cs.rsp.awready) begin
      next_cs.aw_have = 1'b1;
      next_cs.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && cs.rsp.wready) begin
      next_cs.w_have = 1'b1;
      next_cs.w_data = axi_req.wdata;
      next_cs.w_strb = axi_req.wstrb;
    end
    case (cs.wr_state)
      WR_TAKE: begin
        if (cs.aw_have && cs.w_have) begin
          next_cs.aw_have = 1'b0;
          next_cs.w_have = 1'b0;
          next_cs.rsp.bvalid = 1'b1;
          next_cs.rsp.bresp = wslot[4] ? RESP_OKAY : RESP_SLVERR;
          next_cs.wr_state = WR_RESP;
          // Count registers ignore writes
          if (wslot[4] && wslot[3:0] < 4'hC) begin
            if (wslot[0]) begin
              next_cs.cfg[wslot[3:1]].match =
                merge_strb(cs.cfg[wslot[3:1]].match, cs.w_data, cs.w_strb);
            end else begin
              next_cs.cfg[wslot[3:1]].ctrl =
                merge_strb(cs.cfg[wslot[3:1]].ctrl, cs.w_data, cs.w_strb);
            end
            next_cs.dirty = 1'b1;
          end
        end
      end
      WR_RESP: begin
        if (axi_req.bready) begin
          next_cs.rsp.bvalid = 1'b0;
          next_cs.wr_state = WR_TAKE;
        end
      end
      default: begin
        next_cs.wr_state = WR_TAKE;
      end
    endcase
    next_cs.rsp.awready = (next_cs.wr_state == WR_TAKE) && !next_cs.aw_have;
    next_cs.rsp.wready = (next_cs.wr_state == WR_TAKE) && !next_cs.w_have;

    // Read channel
    case (cs.rd_state)
      RD_IDLE: begin
        if (axi_req.arvalid && cs.rsp.arready) begin
          next_cs.rsp.rvalid = 1'b1;
          next_cs.rsp.rresp = rslot[4] ? RESP_OKAY : RESP_SLVERR;
          next_cs.rd_state = RD_RESP;
          if (!rslot[4]) begin
            next_cs.rsp.rdata = 32'h00000000;
          end else if (rslot[3:0] == 4'hC) begin
            next_cs.rsp.rdata = {cs.tx.cmd_b, cs.tx.cmd_r, cs.tx.nonposted_cmd_free_count,
                                 cs.tx.posted_cmd_free_count};
          end else if (rslot[3:0] == 4'hD) begin
            next_cs.rsp.rdata = {8'h00, cs.tx.data_r, cs.tx.nonposted_data_free_count,
                                 cs.tx.posted_data_free_count};
          end else if (rslot[0]) begin
            next_cs.rsp.rdata = cs.cfg[rslot[3:1]].match;
          end else begin
            next_cs.rsp.rdata = cs.cfg[rslot[3:1]].ctrl;
          end
        end
      end
      RD_RESP: begin
        if (axi_req.rready) begin
          next_cs.rsp.rvalid = 1'b0;
          next_cs.rd_state = RD_IDLE;
        end
      end
      default: begin
        next_cs.rd_state = RD_IDLE;
      end
    endcase
    next_cs.rsp.arready = next_cs.rd_state == RD_IDLE;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cs <= '0;
      for (int i = 0; i < NUM_WIN; i++) begin
        cs.cfg[i] <= {WIN_RST, WIN_RST};
        cs.shadow[i] <= {WIN_RST, WIN_RST};
      end
      cs.tx <= {7{TX_FREE_RST}};
      cs.wr_state <= WR_TAKE;
      cs.rd_state <= RD_IDLE;
    end else begin
      cs <= next_cs;
    end
  end

  assign axi_rsp = cs.rsp;

  // ----------------------------------------------------------------
  // Link domain reset release
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      link_rst_sync <= 2'b00;
    end else begin
      link_rst_sync <= {link_rst_sync[0], 1'b1};
    end
  end

  assign link_rst_n = link_rst_sync[1];

  // ----------------------------------------------------------------
  // Link domain
  // ----------------------------------------------------------------
  always_comb begin
    next_ls = ls;

    // Take a new configuration once the shadow is stable
    next_ls.req_sync = {ls.req_sync[0], cs.cfg_req};
    if (ls.req_sync[1] != ls.cfg_ack) begin
      next_ls.cfg = cs.shadow;
      next_ls.cfg_ack = ls.req_sync[1];
    end

    // Offer a count snapshot whenever the last one was taken
    next_ls.tx_ack_sync = {ls.tx_ack_sync[0], cs.tx_ack};
    if (ls.tx_req == ls.tx_ack_sync[1]) begin
      next_ls.tx_hold = tx_free;
      next_ls.tx_req = ~ls.tx_req;
    end

    // Only link requests are decoded here
    next_ls.fwd.valid = rx_req.valid;
    next_ls.fwd.write = rx_req.write;
    next_ls.fwd.route = FWD_INTERNAL;
    next_ls.fwd.addr = {14'h0000, rx_req.addr};
    for (int i = NUM_BYP - 1; i >= 0; i--) begin
      if (win_hit(ls.cfg[i], rx_req.addr)) begin
        next_ls.fwd.route = FWD_BYPASS;
        next_ls.fwd.addr = win_xlat(ls.cfg[i], rx_req.addr);
      end
    end
    // Peer windows evaluated last so they override
    for (int i = NUM_PEER - 1; i >= 0; i--) begin
      if (win_hit(ls.cfg[NUM_BYP + i], rx_req.addr)) begin
        next_ls.fwd.route = FWD_PEER;
        next_ls.fwd.addr = win_xlat(ls.cfg[NUM_BYP + i], rx_req.addr);
      end
    end
  end

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      ls <= '0;
      ls.fwd.route <= FWD_INTERNAL;
    end else begin
      ls <= next_ls;
    end
  end

  assign fwd = ls.fwd;

endmodule : hrw_top

// *** tb/hrw_top_asserts.sv ***
`timescale 1ns/100ps
module hrw_top_asserts
  import hrw_pkg::*;
(
  input wire logic clk, // Register clock
  input wire logic arst_n, // Async reset
  input wire hrw_axi_req_t axi_req, // Bus requests
  input wire hrw_axi_rsp_t axi_rsp, // Bus answers
  input wire logic link_clk, // Link clock
  input wire hrw_req_t rx_req, // Link request
  input wire hrw_txfree_t tx_free, // Free counts
  input wire hrw_fwd_t fwd // Routed request
);
  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  a_write_answer: assert property (@(posedge clk) disable iff (!arst_n)
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
    |-> ##2 axi_rsp.bvalid) else $error("write answer late");
  a_write_busy: assert property (@(posedge clk) disable iff (!arst_n)
    axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready) else $error("write not blocked");
  a_read_answer: assert property (@(posedge clk) disable iff (!arst_n)
    axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid) else $error("read answer late");
  a_read_busy: assert property (@(posedge clk) disable iff (!arst_n)
    axi_rsp.rvalid |-> !axi_rsp.arready) else $error("read not blocked");
  // ----------------------------------------------------------------
  // Link side
  // ----------------------------------------------------------------
  a_fwd_follow: assert property (@(posedge link_clk) disable iff (!arst_n)
    rx_req.valid |=> fwd.valid) else $error("request not forwarded");
  a_fwd_cause: assert property (@(posedge link_clk) disable iff (!arst_n)
    fwd.valid |-> $past(rx_req.valid)) else $error("forward without request");
  a_route_onehot: assert property (@(posedge link_clk) disable iff (!arst_n)
    fwd.valid |-> $onehot(fwd.route)) else $error("route not one-hot");
  a_low_kept: assert property (@(posedge link_clk) disable iff (!arst_n)
    fwd.valid |-> fwd.addr[23:0] == $past(rx_req.addr[23:0])
    && fwd.write == $past(rx_req.write)) else $error("low address or kind changed");
endmodule : hrw_top_asserts

// *** tb/hrw_link_peer.sv ***
`timescale 1ns/100ps
module hrw_link_peer
  import hrw_pkg::*;
(
  input wire logic link_clk, // Link clock
  input wire hrw_txfree_t cnt, // Counts to present
  input wire hrw_fwd_t fwd, // Routed request
  output hrw_req_t rx_req, // Request to block
  output hrw_txfree_t tx_free // Free counts
);
  initial begin
    rx_req = '0;
    tx_free = '0;
  end
  always @(posedge link_clk) begin
    tx_free <= cnt;
  end
  task automatic send(input logic w, input logic [39:0] a, output hrw_fwd_t f);
    @(posedge link_clk);
    rx_req <= {1'b1, w, a};
    @(posedge link_clk);
    // Released lines must not keep the last value
    rx_req <= {1'b0, ~w, ~a};
    #1 f = fwd;
  endtask : send
endmodule : hrw_link_peer

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
module tb_top
  import hrw_pkg::*;
;
  logic clk = 0;
  logic link_clk = 0;
  logic arst_n = 0;
  hrw_axi_req_t req = '0;
  hrw_axi_rsp_t rsp;
  hrw_req_t rx_req;
  hrw_txfree_t tx_free;
  hrw_txfree_t cnt = '0;
  hrw_fwd_t fwd, f;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [3:0] strb = 4'hF;
  logic [11:0] win [6] = '{12'h0F0, 12'h0F8, 12'h168, 12'h170, 12'h158, 12'h160};
  hrw_top uut (.clk(clk), .arst_n(arst_n), .axi_req(req), .axi_rsp(rsp),
    .link_clk(link_clk), .rx_req(rx_req), .tx_free(tx_free), .fwd(fwd));
  hrw_link_peer peer (.link_clk(link_clk), .cnt(cnt), .fwd(fwd), .rx_req(rx_req),
    .tx_free(tx_free));
  initial forever #12.5 clk = ~clk;
  initial begin
    #3;
    forever #15 link_clk = ~link_clk;
  end
  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, s, e);
    end
  endtask : chk
  task automatic results;
    if (n_errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= strb;
    req.bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) break;
    end
    req.bready <= 1'b0;
    chk(rsp.bresp, er);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) break;
    end
    req.rready <= 1'b0;
    chk({rsp.rresp, rsp.rdata}, {er, ed});
  endtask : rd
  function automatic logic [53:0] xl(logic [31:0] c, logic [31:0] m, logic [39:0] a);
    return c[30] ? {c[29:16], (a[39:24] & ~m[15:0]) | (c[15:0] & m[15:0]), a[23:0]}
      : {14'h0, a};
  endfunction : xl
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic regs_test;
    for (int a = 32'h0F0; a < 32'h178; a += 4) begin
      if (a < 32'h100 || a >= 32'h158) begin
        rd(a[11:0], 32'h0, RESP_OKAY);
        wr(a[11:0], 32'hA5C3_3C5A, RESP_OKAY);
        rd(a[11:0], 32'hA5C3_3C5A, RESP_OKAY);
        wr(a[11:0], 32'h0, RESP_OKAY);
      end
    end
  endtask : regs_test
  task automatic strb_test;
    strb = 4'h5;
    wr(12'h0F4, 32'hFFFF_FFFF, RESP_OKAY);
    strb = 4'hF;
    rd(12'h0F4, 32'h00FF_00FF, RESP_OKAY);
    wr(12'h0F4, 32'h0000_0000, RESP_OKAY);
    rd(12'h0F4, 32'h0000_0000, RESP_OKAY);
  endtask : strb_test
  task automatic bad_test;
    wr(12'h108, 32'hFFFF_FFFF, RESP_SLVERR);
    rd(12'h0F2, 32'h0, RESP_SLVERR);
    wr(12'h100, 32'hFFFF_FFFF, RESP_OKAY);
    rd(12'h100, 32'h0, RESP_OKAY);
  endtask : bad_test
  task automatic count_test;
    @(posedge link_clk);
    cnt <= 56'h11_2233_4455_6677;
    repeat (20) @(posedge clk);
    rd(12'h100, 32'h1122_3344, RESP_OKAY);
    rd(12'h104, 32'h0055_6677, RESP_OKAY);
  endtask : count_test
  task automatic win_test;
    logic [31:0] c;
    for (int i = 0; i < 6; i++) begin
      c = {1'b1, i[0], 14'h2A5, 16'hAB00};
      wr(win[i], c, RESP_OKAY);
      wr(win[i] + 12'h4, 32'h1200_FF00, RESP_OKAY);
      repeat (10) @(posedge clk);
      peer.send(1'b1, 40'h12_3456_789A, f);
      chk({f.valid, f.write, f.route}, {2'b11, i < 4 ? FWD_BYPASS : FWD_PEER});
      chk(f.addr, xl(c, 32'h1200_FF00, 40'h12_3456_789A));
      peer.send(1'b0, 40'h13_3456_789A, f);
      chk({f.valid, f.write, f.route}, {2'b10, FWD_INTERNAL});
      chk(f.addr, {14'h0000, 40'h13_3456_789A});
      wr(win[i], 32'h0, RESP_OKAY);
    end
  endtask : win_test
  task automatic overlap_test;
    wr(12'h0F0, 32'hC000_0000, RESP_OKAY);
    wr(12'h0F8, 32'hC000_1100, RESP_OKAY);
    wr(12'h160, 32'h8000_0000, RESP_OKAY);
    repeat (20) @(posedge clk);
    peer.send(1'b1, 40'h12_0000_0001, f);
    chk({f.route, f.addr}, {FWD_PEER, 54'h12_0000_0001});
    // Peer gone: lowest bypass window wins and translates
    wr(12'h160, 32'h0000_0000, RESP_OKAY);
    repeat (20) @(posedge clk);
    peer.send(1'b0, 40'h12_0000_0001, f);
    chk({f.route, f.addr}, {FWD_BYPASS, 54'h00_0000_0001});
  endtask : overlap_test
  // ----------------------------------------------------------------
  // Main sequence and timeout
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    regs_test();
    strb_test();
    bad_test();
    count_test();
    win_test();
    overlap_test();
    results();
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end
endmodule : tb_top
bind hrw_top hrw_top_asserts chk_i (.clk(clk), .arst_n(arst_n), .axi_req(axi_req),
  .axi_rsp(axi_rsp), .link_clk(link_clk), .rx_req(rx_req), .tx_free(tx_free), .fwd(fwd));
